// ===== design/rfq_pkg.sv
// Package for the ring frequency qualifier: field widths, delay codes
// and tick timing. Assumes a single 125 MHz system clock.
package rfq_pkg;
  localparam int RFQ_CLK_MHZ = 125;
  localparam int RFQ_TICK_US = 2000;  // Nominal interval tick, 2.0 ms
  localparam int RFQ_TICK_CYC = RFQ_TICK_US * RFQ_CLK_MHZ;
  localparam int RFQ_CNT_W = 6;
  localparam int RFQ_DLY_W = 3;
  localparam int RFQ_DLY_UNIT_MS = 256;  // Delay step per code unit
  localparam int RFQ_DLY_CYC = RFQ_DLY_UNIT_MS * 1000 * RFQ_CLK_MHZ;
  localparam int RFQ_TW = 32;
  localparam logic [RFQ_CNT_W-1:0] RFQ_CNT_ZERO = 6'h00;
  localparam logic [RFQ_CNT_W-1:0] RFQ_CNT_ONE = 6'h01;
  localparam logic [RFQ_DLY_W-1:0] RFQ_DLY_NONE = 3'h0;
  localparam logic [RFQ_DLY_W-1:0] RFQ_DLY_ONE = 3'h1;
  typedef enum logic [1:0] {
    RFQ_IDLE = 2'h0,
    RFQ_QUAL = 2'h1,
    RFQ_WAIT = 2'h3,
    RFQ_VALID = 2'h2
  } rfq_state_t;
endpackage

// ===== design/rfq_tick_gen.sv
// Tick generator: one-cycle pulse every PERIOD clocks.
// Assumes a single clock domain with synchronous active-high reset.
`timescale 1ns/10ps
module rfq_tick_gen #(
  parameter int PERIOD = rfq_pkg::RFQ_TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Restart and tick
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic hit;

  // Restart realigns the tick phase to the latest event
  assign hit = (cnt_q == 32'(PERIOD - 1));
  assign cnt_d = (restart || hit) ? 32'h0 : cnt_q + 32'h1;

  // Counter register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick <= hit && !restart;
    end
  end
endmodule

// ===== design/rfq_top.sv
// Ring frequency qualifier: spacing check on ring threshold events and
// delayed valid-ring indication. Assumes events come from a line-side
// detector on another clock and settings are held steady by software.
`timescale 1ns/10ps
module rfq_top
  import rfq_pkg::*;
#(
  parameter int TICK_CYC = rfq_pkg::RFQ_TICK_CYC,
  parameter int DLY_CYC = rfq_pkg::RFQ_DLY_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Line side ring event and software qualification request
  input wire logic ring_event,
  input wire logic ring_qual_en,
  // Software settings
  input wire logic [rfq_pkg::RFQ_CNT_W-1:0] ring_start_count,
  input wire logic [rfq_pkg::RFQ_CNT_W-1:0] ring_gap_limit_count,
  input wire logic [rfq_pkg::RFQ_DLY_W-1:0] ring_indicate_delay,
  // Status
  output logic ring_too_fast,
  output logic ring_valid,
  output logic [rfq_pkg::RFQ_CNT_W-1:0] ring_timer
);
  import rfq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Event synchroniser and edge detect
  logic ev_s1_q;
  logic ev_s2_q;
  logic ev_s3_q;
  logic ev_pulse;

  // Two flops before any logic; third flop only for the edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end
    else
    begin
      ev_s1_q <= ring_event;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end
  // One event per threshold crossing, i.e. two per tone period
  assign ev_pulse = ev_s2_q && !ev_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Interval timer
  logic tick;
  logic [RFQ_CNT_W-1:0] timer_q;
  logic [RFQ_CNT_W-1:0] timer_d;
  logic armed_q;
  logic too_fast_hit;

  rfq_tick_gen #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(ev_pulse),
    .tick(tick)
  );

  // Gap shorter than start minus limit ticks leaves timer above limit
  assign too_fast_hit = ev_pulse && armed_q
                        && (timer_q > ring_gap_limit_count);
  // Load on event, else count down and stick at zero
  assign timer_d = ev_pulse ? ring_start_count :
                   (tick && timer_q != RFQ_CNT_ZERO) ?
                   timer_q - RFQ_CNT_ONE : timer_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      timer_q <= RFQ_CNT_ZERO;
    end
    else
    begin
      timer_q <= timer_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Qualification state machine
  rfq_state_t st_q;
  rfq_state_t st_d;
  logic [31:0] dly_q;
  logic [31:0] dly_d;
  logic [31:0] dly_target;
  logic dly_done;

  // Delay is code times 256 ms; code zero indicates at once
  assign dly_target = 32'(ring_indicate_delay) * 32'(DLY_CYC);
  assign dly_done = (dly_q >= dly_target);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      RFQ_IDLE: if (ring_qual_en) st_d = RFQ_QUAL;
      RFQ_QUAL:
        if (!ring_qual_en) st_d = RFQ_IDLE;
        else if (ev_pulse && armed_q && !too_fast_hit) st_d = RFQ_WAIT;
      RFQ_WAIT:
        if (!ring_qual_en || too_fast_hit) st_d = RFQ_QUAL;
        else if (dly_done) st_d = RFQ_VALID;
      RFQ_VALID:
        if (!ring_qual_en || too_fast_hit) st_d = RFQ_QUAL;
      default: st_d = RFQ_IDLE;
    endcase
  end

  assign dly_d = (st_q == RFQ_WAIT) ? dly_q + 32'h1 : 32'h0;

  // State, delay counter and status outputs
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q <= RFQ_IDLE;
      dly_q <= 32'h0;
      armed_q <= 1'b0;
      ring_too_fast <= 1'b0;
      ring_valid <= 1'b0;
      ring_timer <= RFQ_CNT_ZERO;
    end
    else
    begin
      st_q <= st_d;
      dly_q <= dly_d;
      // First event only arms; a gap needs two events
      armed_q <= (st_d != RFQ_IDLE) && (armed_q || ev_pulse);
      if (too_fast_hit)
        ring_too_fast <= 1'b1;
      else if (ev_pulse || !ring_qual_en)
        ring_too_fast <= 1'b0;
      ring_valid <= (st_d == RFQ_VALID);
      ring_timer <= timer_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_load;
    @(posedge mclk) disable iff (sys_rst)
    ev_pulse |=> (timer_q == $past(ring_start_count));
  endproperty
  a_load: assert property (p_load)
    else $error("timer not loaded on event");

  property p_hold_zero;
    @(posedge mclk) disable iff (sys_rst)
    (timer_q == RFQ_CNT_ZERO && !ev_pulse) |=> (timer_q == RFQ_CNT_ZERO);
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("timer wrapped below zero");

  property p_down;
    @(posedge mclk) disable iff (sys_rst)
    (tick && !ev_pulse && timer_q != RFQ_CNT_ZERO)
      |=> (timer_q == $past(timer_q) - RFQ_CNT_ONE);
  endproperty
  a_down: assert property (p_down)
    else $error("timer did not step down on tick");

  property p_still;
    @(posedge mclk) disable iff (sys_rst)
    (!tick && !ev_pulse) |=> $stable(timer_q);
  endproperty
  a_still: assert property (p_still)
    else $error("timer moved without tick");

  property p_fast;
    @(posedge mclk) disable iff (sys_rst)
    (ev_pulse && armed_q && timer_q > ring_gap_limit_count)
      |=> ring_too_fast && !ring_valid;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast ring not invalidated");

  property p_limit;
    @(posedge mclk) disable iff (sys_rst)
    (st_q == RFQ_QUAL && ev_pulse && armed_q
      && timer_q <= ring_gap_limit_count && ring_qual_en)
      |=> st_q == RFQ_WAIT;
  endproperty
  a_limit: assert property (p_limit)
    else $error("in-range ring not accepted");

  property p_delay;
    @(posedge mclk) disable iff (sys_rst)
    $rose(ring_valid) |-> $past(dly_q) >= $past(dly_target);
  endproperty
  a_delay: assert property (p_delay)
    else $error("valid ring raised before delay");

  property p_nodelay;
    @(posedge mclk) disable iff (sys_rst)
    (st_q == RFQ_WAIT && ring_indicate_delay == RFQ_DLY_NONE
      && ring_qual_en && !too_fast_hit) |=> ring_valid;
  endproperty
  a_nodelay: assert property (p_nodelay)
    else $error("zero delay not immediate");
endmodule

// ===== test/rfq_line_model.sv
// Line-side ring threshold detector model for the qualifier bench.
// Assumes one clock; the bench sets the half period in clock cycles.
`timescale 1ns/10ps
module rfq_line_model (
  // Clock
  input wire logic mclk,
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] half_cyc,
  // Detector output
  output logic ring_event
);
  logic [15:0] cnt_q;
  // No initial values: run starts low, so the first edge clears both
  ////////////////////////////////////////////////////////////////////
  // One pulse per half period of the tone; low when stopped
  always @(posedge mclk)
  begin
    if (!run)
    begin
      cnt_q <= 16'h0000;
      ring_event <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == half_cyc - 16'h0001) ? 16'h0000 : cnt_q + 1'b1;
      ring_event <= (cnt_q < 16'h0002);
    end
  end
endmodule

// ===== test/rfq_top_bench.sv
// Self-checking bench for the ring frequency qualifier.
// Assumes short tick and delay units: 10 and 20 clocks.
`timescale 1ns/10ps
module rfq_top_bench;
  import rfq_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, run = 1'b0, qual_en = 1'b0;
  logic [15:0] half = 16'h0064;
  logic [5:0] start = 6'h08, limit = 6'h05, timer; // Bound 4, plus 1
  logic [2:0] dly = 3'h0;
  logic ev, fast, valid;
  int bad_count = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz
  initial forever #4 mclk = ~mclk;
  rfq_line_model line (.mclk(mclk), .run(run), .half_cyc(half),
    .ring_event(ev));
  rfq_top #(.TICK_CYC(10), .DLY_CYC(20)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .ring_event(ev), .ring_qual_en(qual_en),
    .ring_start_count(start), .ring_gap_limit_count(limit),
    .ring_indicate_delay(dly), .ring_too_fast(fast), .ring_valid(valid),
    .ring_timer(timer));
  ////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Event at time 0, and at h when w is at least h; stopped before a third one
  task automatic pulse(input logic [15:0] h, input int w);
    @(posedge mclk);
    half <= h;
    run <= 1'b1;
    tick(w);
    @(posedge mclk);
    run <= 1'b0;
    tick(1);
  endtask
  // Disabling clears the status, then qualification restarts
  task automatic reen;
    @(posedge mclk);
    qual_en <= 1'b0;
    tick(3);
    chk({4'h0, fast, valid}, 6'h00);
    @(posedge mclk);
    qual_en <= 1'b1;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_timer;
    reen();
    pulse(16'h0064, 1);
    tick(2);
    chk(timer, start);
    tick(30);
    chk(timer, start - 6'h03);
    tick(150);
    chk(timer, 6'h00);
    $display("test timer done");
  endtask
  task automatic t_fast;
    reen();
    pulse(16'h000f, 16);
    tick(3);
    chk({4'h0, fast, valid}, 6'h02);
    $display("test fast done");
  endtask
  // Timer equal to the limit is not above it, so the ring is accepted
  task automatic t_edge;
    reen();
    @(posedge mclk);
    limit <= 6'h07;
    pulse(16'h000f, 16);
    tick(3);
    chk({4'h0, fast, valid}, 6'h00);
    @(posedge mclk);
    limit <= 6'h05;
    $display("test edge done");
  endtask
  task automatic t_delay(input logic [2:0] code);
    int n;
    reen();
    @(posedge mclk);
    dly <= code;
    pulse(16'h003c, 61);
    n = 0;
    while (valid !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    if (n >= 300)
    begin
      bad_count++;
      results();
    end
    chk(6'(n >= 20 * code && n <= 20 * code + 10), 6'h01);
    chk({5'h00, fast}, 6'h00);
    $display("test delay %0d done", code);
  endtask
  // A fast pair while valid drops the indication
  task automatic t_drop;
    chk({4'h0, fast, valid}, 6'h01);
    pulse(16'h000f, 16);
    tick(3);
    chk({4'h0, fast, valid}, 6'h02);
    $display("test drop done");
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
    chk({fast, valid, 4'h0}, 6'h00);
    chk(timer, 6'h00);
    t_timer();
    t_fast();
    t_delay(3'h0);
    t_delay(3'h1);
    t_delay(3'h2);
    t_delay(3'h7);
    t_drop();
    t_edge();
    results();
  end
endmodule
